// file: verilog/ilr_level_regs.sv
// interrupt level assignment register bank with access gating
//
// Summary of operation
// [R1] each 2-bit field: 00 lowest level one through 11 highest level four.
// [R2] every field sets the level of one maskable source; nmi takes none.
// [R3] writes of level registers take effect only while control is on; reads return stored contents either way.
// [R4] writes while control is off are dropped; contents stay.
// [R5] reads while off return held contents, or reset value if never enabled.
// [R6] software writes levels after reset, before enabling any interrupt.
// [R7] register a at F025: one field in bits 5:4, rest read zero.
// [R8] register b at F026: four fields 7:6, 5:4, 3:2, 1:0.
// [R9] register c at F027: four fields 7:6, 5:4, 3:2, 1:0.
// [R10] register d at F028: fields 5:4 and 1:0, bits 7:6 and 3:2 read zero.
// [R11] register e at F029: field in bits 7:6, bits 5:0 read zero.
// [R12] all level registers are 8-bit and reset to 00.
// [R13] enable register bit 0 switches level control on and opens access.
// [R14] software clears in-service and level registers to 00 before turning off.
// [R15] maskable requests below the highest in-service level are refused.
// [R16] stored fields feed priority logic directly, no added delay.
`include "ilr_regs.svh"
module ilr_level_regs
  import ilr_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_reset,
  input  wire logic [15:0]             i_addr,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  input  wire logic [7:0]              i_wdata,
  input  wire logic [1:0]              i_accept_lvl,
  input  wire logic                    i_accept_mask,
  input  wire logic                    i_accept_nmi,
  input  wire logic [12:0]             i_req,
  input  wire logic                    i_nmi_req,
  output logic      [7:0]              o_rdata,
  output logic      [25:0]             o_levels,
  output logic                         o_level_ctrl_on,
  output logic      [12:0]             o_req_ok,
  output logic                         o_nmi_ok
);
  import ilr_pkg::*;

  typedef struct packed {
    ilr_byte_t enable;
    ilr_byte_t insvc;
    ilr_byte_t sel_a;
    ilr_byte_t sel_b;
    ilr_byte_t sel_c;
    ilr_byte_t sel_d;
    ilr_byte_t sel_e;
    ilr_byte_t rdata;
  } ilr_state_s;

  ilr_state_s st_q;
  ilr_state_s st_d;
  ilr_bus_if  lv ();

  ////////////////////////////////////////////////////////////////////////////
  // highest set bit cleared by an in-service write
  function automatic ilr_byte_t clr_top(input ilr_byte_t v);
    ilr_byte_t r;
    logic      done;
    r    = v;
    done = 1'b0;
    for (int k = 7; k >= 0; k--)
    begin
      if (!done && r[k])
      begin
        r[k] = 1'b0;
        done = 1'b1;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic on;
    on   = st_q.enable[`ILR_BIT_ENABLE];
    st_d = st_q;
    // read data: gated registers keep presenting stored values while off,
    // which is exactly the held-since-last-enable content
    case (i_addr)
      `ILR_OFF_ENABLE: st_d.rdata = st_q.enable & `ILR_MASK_ENABLE;
      `ILR_OFF_INSVC:  st_d.rdata = st_q.insvc & `ILR_MASK_INSVC; // R5
      `ILR_OFF_SEL_A:  st_d.rdata = st_q.sel_a & `ILR_MASK_SEL_A; // R7 R5
      `ILR_OFF_SEL_B:  st_d.rdata = st_q.sel_b & `ILR_MASK_SEL_B; // R8
      `ILR_OFF_SEL_C:  st_d.rdata = st_q.sel_c & `ILR_MASK_SEL_C; // R9
      `ILR_OFF_SEL_D:  st_d.rdata = st_q.sel_d & `ILR_MASK_SEL_D; // R10
      `ILR_OFF_SEL_E:  st_d.rdata = st_q.sel_e & `ILR_MASK_SEL_E; // R11
      default:         st_d.rdata = `ILR_RESET_VAL;
    endcase
    if (!i_rd)
    begin
      st_d.rdata = st_q.rdata;
    end
    // acceptance marks in service; an accept in the same cycle as a clear wins
    if (i_wr && on && (i_addr == `ILR_OFF_INSVC))
    begin
      st_d.insvc = clr_top(st_q.insvc);
    end
    if (on && i_accept_nmi)
    begin
      st_d.insvc[`ILR_BIT_NMI_SVC] = 1'b1;
    end
    if (on && i_accept_mask)
    begin
      st_d.insvc[i_accept_lvl] = 1'b1;
    end
    if (i_wr)
    begin
      case (i_addr)
        `ILR_OFF_ENABLE: st_d.enable = i_wdata & `ILR_MASK_ENABLE; // R13
        `ILR_OFF_SEL_A:  if (on) st_d.sel_a = i_wdata & `ILR_MASK_SEL_A; // R3 R4 R7
        `ILR_OFF_SEL_B:  if (on) st_d.sel_b = i_wdata & `ILR_MASK_SEL_B; // R3 R4 R8
        `ILR_OFF_SEL_C:  if (on) st_d.sel_c = i_wdata & `ILR_MASK_SEL_C; // R3 R4 R9
        `ILR_OFF_SEL_D:  if (on) st_d.sel_d = i_wdata & `ILR_MASK_SEL_D; // R3 R4 R10
        `ILR_OFF_SEL_E:  if (on) st_d.sel_e = i_wdata & `ILR_MASK_SEL_E; // R3 R4 R11
        default:         st_d.enable = st_q.enable;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      st_q <= '0; // R12
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level fields straight from the flops, one per source, lsb register first
  // two spare msbs stay zero: 13 sources fill all 26 bits as 2-bit fields
  // but the five registers hold just 12 writable fields
  assign lv.levels = {2'b00,
                      st_q.sel_e[7:6],
                      st_q.sel_d[5:4], st_q.sel_d[1:0],
                      st_q.sel_c,
                      st_q.sel_b,
                      st_q.sel_a[5:4]}; // R16 R2 R1
  assign lv.svc_maskable = st_q.insvc[3:0];
  assign lv.svc_nmi      = st_q.insvc[`ILR_BIT_NMI_SVC];
  assign lv.ctrl_on      = st_q.enable[`ILR_BIT_ENABLE];

  assign o_rdata         = st_q.rdata;
  assign o_levels        = lv.levels;
  assign o_level_ctrl_on = lv.ctrl_on;

  ilr_accept_gate u_gate (
    .lv        (lv.gate),
    .i_req     (i_req),
    .i_nmi_req (i_nmi_req),
    .o_req_ok  (o_req_ok),
    .o_nmi_ok  (o_nmi_ok)
  );
endmodule // ilr_level_regs

// file: verilog/ilr_regs.svh
// register map, field layout and reset values of the interrupt level block
`ifndef ILR_REGS_SVH
`define ILR_REGS_SVH
`define ILR_ADDR_W        16
`define ILR_DATA_W        8
`define ILR_OFF_ENABLE    16'hF020
`define ILR_OFF_INSVC     16'hF022
`define ILR_OFF_SEL_A     16'hF025
`define ILR_OFF_SEL_B     16'hF026
`define ILR_OFF_SEL_C     16'hF027
`define ILR_OFF_SEL_D     16'hF028
`define ILR_OFF_SEL_E     16'hF029
`define ILR_MASK_SEL_A    8'h30
`define ILR_MASK_SEL_B    8'hFF
`define ILR_MASK_SEL_C    8'hFF
`define ILR_MASK_SEL_D    8'h33
`define ILR_MASK_SEL_E    8'hC0
`define ILR_MASK_ENABLE   8'h01
`define ILR_MASK_INSVC    8'h8F
`define ILR_RESET_VAL     8'h00
`define ILR_BIT_ENABLE    0
`define ILR_BIT_NMI_SVC   7
`define ILR_NUM_SRC       13
`define ILR_NUM_REGS      5
`endif

// file: verilog/ilr_pkg.sv
// types shared by the interrupt level block
package ilr_pkg;
  typedef logic [1:0] ilr_level_t;
  typedef logic [7:0] ilr_byte_t;
  typedef logic [3:0] ilr_lvl_onehot_t;
endpackage

// file: verilog/ilr_bus_if.sv
// internal carrier between the register bank and the acceptance gate
interface ilr_bus_if;
  logic [25:0] levels;
  logic [3:0]  svc_maskable;
  logic        svc_nmi;
  logic        ctrl_on;
  modport bank (output levels, output svc_maskable, output svc_nmi, output ctrl_on);
  modport gate (input levels, input svc_maskable, input svc_nmi, input ctrl_on);
endinterface

// file: verilog/ilr_accept_gate.sv
// per-source acceptance gate against the highest in-service level
`include "ilr_regs.svh"
module ilr_accept_gate
  import ilr_pkg::*;
(
  ilr_bus_if.gate                      lv,
  input  wire logic [12:0]             i_req,
  input  wire logic                    i_nmi_req,
  output logic      [12:0]             o_req_ok,
  output logic                         o_nmi_ok
);
  // highest marked level as a one-hot threshold; empty means nothing in service
  function automatic logic below_svc(input ilr_level_t lvl, input ilr_lvl_onehot_t svc);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      if (svc[k] && (k > int'(lvl)))
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction
  always_comb
  begin
    for (int s = 0; s < `ILR_NUM_SRC; s++)
    begin
      // nmi in service blocks every maskable source while level control is on
      o_req_ok[s] = i_req[s] && !(lv.ctrl_on &&
                    (lv.svc_nmi || below_svc(lv.levels[2*s +: 2], lv.svc_maskable))); // R15
    end
    o_nmi_ok = i_nmi_req; // R2
  end
endmodule // ilr_accept_gate

// file: dv/ilr_core_model.sv
// processor core stand-in that takes maskable source 0 as a one-cycle accept
module ilr_core_model (
  input  wire logic        i_clock,
  input  wire logic [12:0] i_req_ok,
  input  wire logic [25:0] i_levels,
  output logic             o_acc,
  output logic [1:0]       o_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_acc = 1'b0;
  // one pulse every other cycle while source 0 is ok, taken at the level the bank shows for that source
  always @(posedge i_clock)
  begin
    o_acc <= i_req_ok[0] & ~o_acc;
    o_lvl <= i_levels[1:0];
  end
endmodule // ilr_core_model

// file: dv/ilr_level_regs_sva.sv
// concurrent checks on the level register bank ports
module ilr_level_regs_sva (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic [15:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic [25:0] o_levels,
  input wire logic        o_level_ctrl_on
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  logic wr_on;
  assign wr_on = i_wr && o_level_ctrl_on;
  ////////////////////////////////////////
  a_ctrl_bit:
    assert property (i_wr && i_addr == 16'hF020 |=> o_level_ctrl_on == $past(i_wdata[0]))
    else $error("enable bit");
  a_locked_write:
    assert property (i_wr && !o_level_ctrl_on && i_addr != 16'hF020 |=> $stable(o_levels))
    else $error("write while off");
  a_sel_b_write:
    assert property (wr_on && i_addr == 16'hF026 |=> o_levels[9:2] == $past(i_wdata))
    else $error("sel b field");
  a_sel_a_write:
    assert property (wr_on && i_addr == 16'hF025 |=> o_levels[1:0] == $past(i_wdata[5:4]))
    else $error("sel a field");
  a_sel_e_write:
    assert property (wr_on && i_addr == 16'hF029 |=> o_levels[23:22] == $past(i_wdata[7:6]))
    else $error("sel e field");
  a_rdata_held:
    assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved");
  a_rd_d_zero:
    assert property (i_rd && i_addr == 16'hF028 |=> (o_rdata & 8'hCC) == 8'h00)
    else $error("sel d zero bits");
  a_rd_a_match:
    assert property (i_rd && i_addr == 16'hF025 |=> o_rdata == {2'b00, o_levels[1:0], 4'h0})
    else $error("sel a read");
  c_off: cover property (i_wr && !o_level_ctrl_on && i_addr == 16'hF026);
  c_on: cover property (wr_on && i_addr == 16'hF029);
  c_rd: cover property (i_rd && i_addr == 16'hF025);
endmodule // ilr_level_regs_sva
bind ilr_level_regs ilr_level_regs_sva chk (.*);

// file: dv/test_ilr_level_regs.sv
// self-checking bench for the interrupt level register bank
module test_ilr_level_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_accept_mask, i_accept_nmi = 1'b0, i_nmi_req = 1'b0;
  logic        o_level_ctrl_on, o_nmi_ok;
  logic [1:0]  i_accept_lvl;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_wdata = 8'h00, o_rdata;
  logic [12:0] i_req = 13'h0000, o_req_ok;
  logic [25:0] o_levels;
  int          miscompares = 0, n_checks = 0;
  always #20 i_clock = ~i_clock;
  ilr_level_regs dut (.*);
  ilr_core_model core (.i_clock(i_clock), .i_req_ok(o_req_ok), .i_levels(o_levels),
    .o_acc(i_accept_mask), .o_lvl(i_accept_lvl));
  ////////////////////////////////////////
  task automatic chk(string what, logic [25:0] exp, logic [25:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clock);
    i_wr = 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clock);
    i_rd = 1'b0;
    chk("rdata", {18'h0, e}, {18'h0, o_rdata});
  endtask
  task automatic t_reset();
    logic [15:0] a [6] = '{16'hF020, 16'hF022, 16'hF025, 16'hF027, 16'hF029, 16'hF030};
    foreach (a[i]) rd(a[i], 8'h00);
  endtask
  task automatic t_masks();
    logic [7:0] m [5] = '{8'h30, 8'hFF, 8'hFF, 8'h33, 8'hC0};
    wr(16'hF020, 8'h01);
    foreach (m[i])
    begin
      wr(16'hF025 + 16'(i), 8'hFF);
      rd(16'hF025 + 16'(i), m[i]);
    end
    chk("levels", 26'h0FFFFFF, o_levels);
  endtask
  task automatic t_held();
    wr(16'hF026, 8'hE4);
    chk("levels", 26'h0FFFF93, o_levels);
    wr(16'hF020, 8'h00);
    wr(16'hF026, 8'h1B);
    rd(16'hF026, 8'hE4);
    chk("levels", 26'h0FFFF93, o_levels);
    wr(16'hF020, 8'h01);
  endtask
  // source 0 sits at level four, source 1 at level one
  task automatic t_gate();
    i_req = 13'h0001;
    @(negedge i_clock);
    i_req = 13'h0002;
    @(negedge i_clock);
    chk("req_ok", 26'h0, {13'h0, o_req_ok});
    wr(16'hF022, 8'h00);
    chk("req_ok", 26'h2, {13'h0, o_req_ok});
    i_req = 13'h0000;
  endtask
  // nmi in service blocks maskable source 0; an in-service write then clears it
  task automatic t_nmi();
    i_nmi_req = 1'b1;
    i_accept_nmi = 1'b1;
    @(negedge i_clock);
    i_accept_nmi = 1'b0;
    chk("nmi_ok", 26'h1, {25'h0, o_nmi_ok});
    i_req = 13'h0001;
    @(negedge i_clock);
    chk("req_ok", 26'h0, {13'h0, o_req_ok});
    i_req = 13'h0000;
    rd(16'hF022, 8'h80);
    wr(16'hF022, 8'h00);
    rd(16'hF022, 8'h00);
    i_nmi_req = 1'b0;
    @(negedge i_clock);
    chk("nmi_ok", 26'h0, {25'h0, o_nmi_ok});
  endtask
  // software returns every level register to zero before switching control off
  task automatic t_off();
    for (int i = 0; i < 5; i++)
    begin
      wr(16'hF025 + 16'(i), 8'h00);
    end
    wr(16'hF020, 8'h00);
    chk("levels", 26'h0, o_levels);
    chk("ctrl_on", 26'h0, {25'h0, o_level_ctrl_on});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge i_clock);
    i_reset = 1'b0;
    t_reset();
    wr(16'hF026, 8'hFF);
    rd(16'hF026, 8'h00);
    t_masks();
    t_held();
    t_gate();
    t_nmi();
    t_off();
    wrap_up();
  end
endmodule // test_ilr_level_regs
